// File: inc/sram_port_defines.svh
// constants for the flow-through burst sram port
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH
`define SRAM_ADDR_W   20
`define SRAM_DATA_W   16
`define SRAM_LANES    2
`define SRAM_LANE_W   8
`define SRAM_DEPTH    1048576
`define SRAM_LOW_W    2
`define SRAM_HI_LSB   2
`define SRAM_CNT_ZERO 2'h0
`define SRAM_CNT_ONE  2'h1
`define SRAM_MASK_ALL 2'h3
`define SRAM_MASK_NONE 2'h0
`endif

// File: inc/sram_port_pkg.sv
// types shared by the flow-through burst sram port
`include "sram_port_defines.svh"
package sram_port_pkg;
  typedef logic [`SRAM_ADDR_W-1:0] addr_t;
  typedef logic [`SRAM_LANES-1:0]  lane_mask_t;
  typedef logic [`SRAM_LOW_W-1:0]  burst_t;
  typedef struct packed {
    logic [`SRAM_LANES-1:0]  parity;
    logic [`SRAM_DATA_W-1:0] data;
  } word_s;
  typedef enum logic [3:0] {
    ST_DESEL = 4'b0001,
    ST_READ  = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_SLEEP = 4'b1000
  } state_e;
endpackage

// File: src/flow_through_burst_sram_port.sv
// flow-through burst sram port with 1M x 18 array
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_defines.svh"
module flow_through_burst_sram_port
  import sram_port_pkg::*;
(
  input  wire logic                      REF_CLK,
  input  wire logic                      RSTN,
  input  wire logic [`SRAM_ADDR_W-1:0]   ADDR,
  input  wire logic                      CHIP_SELECT_A_N,
  input  wire logic                      CHIP_SELECT_B,
  input  wire logic                      CHIP_SELECT_C_N,
  input  wire logic                      PROCESSOR_ADDR_STROBE_N,
  input  wire logic                      CONTROLLER_ADDR_STROBE_N,
  input  wire logic                      BURST_ADVANCE_N,
  input  wire logic                      GLOBAL_WRITE_N,
  input  wire logic                      BYTE_WRITE_ENABLE_N,
  input  wire logic [`SRAM_LANES-1:0]    BYTE_LANE_WRITE_SELECT_N,
  input  wire logic                      OUTPUT_ENABLE_N,
  input  wire logic                      SLEEP_REQUEST,
  input  wire logic                      BURST_ORDER,
  input  wire logic [`SRAM_DATA_W-1:0]   DATA_IN,
  input  wire logic [`SRAM_LANES-1:0]    PARITY_LANES_IN,
  output logic      [`SRAM_DATA_W-1:0]   DATA_OUT,
  output logic      [`SRAM_LANES-1:0]    PARITY_LANES_OUT,
  output logic                           LANES_OE_N,
  output logic                           SLEEP_ACTIVE
);

  word_s      mem [`SRAM_DEPTH];
  state_e     state_q;
  logic       first_q;
  logic       order_q;
  logic [`SRAM_ADDR_W-1:`SRAM_HI_LSB] hi_q;
  burst_t     base_q;
  burst_t     cnt_q;
  logic       wr_pend_q;
  addr_t      wr_addr_q;
  word_s      wdata_q;
  lane_mask_t wr_mask_q;

  logic       selected;
  logic       processor_addr_strobe_ok;
  logic       controller_addr_strobe_ok;
  logic       strobe;
  logic       start;
  logic       desel;
  logic       active;
  logic       burst_advance_n;
  logic       wr_now;
  lane_mask_t wmask;
  addr_t      cur_addr;
  addr_t      eff_addr;
  word_s      rd_word;

  // next burst low bits from loaded base and running count
  function automatic burst_t burst_low(input burst_t base, input burst_t cnt,
                                       input logic interleave);
    burst_low = interleave ? (base ^ cnt) : burst_t'(base + cnt);
  endfunction

  // lanes written by the sampled write enables
  function automatic lane_mask_t lane_mask(input logic gw_n, input logic bwe_n,
                                           input lane_mask_t bw_n);
    if (!gw_n) begin
      lane_mask = `SRAM_MASK_ALL;
    end else if (!bwe_n) begin
      lane_mask = ~bw_n;
    end else begin
      lane_mask = `SRAM_MASK_NONE;
    end
  endfunction

  // merge a pending lane write over an older word
  function automatic word_s merge(input word_s old, input word_s nw,
                                  input lane_mask_t m);
    merge = old;
    for (int i = 0; i < `SRAM_LANES; i++) begin
      if (m[i]) begin
        merge.data[i*`SRAM_LANE_W +: `SRAM_LANE_W] = nw.data[i*`SRAM_LANE_W +: `SRAM_LANE_W];
        merge.parity[i] = nw.parity[i];
      end
    end
  endfunction

  assign selected = !CHIP_SELECT_A_N && CHIP_SELECT_B && !CHIP_SELECT_C_N;
  assign processor_addr_strobe_ok  = !PROCESSOR_ADDR_STROBE_N && !CHIP_SELECT_A_N && !SLEEP_REQUEST;
  assign controller_addr_strobe_ok  = !CONTROLLER_ADDR_STROBE_N && !processor_addr_strobe_ok && !SLEEP_REQUEST;
  assign strobe   = processor_addr_strobe_ok || controller_addr_strobe_ok;
  assign start    = strobe && selected;
  assign desel    = strobe && !selected;
  assign active   = (state_q == ST_READ) || (state_q == ST_WRITE);
  assign burst_advance_n      = !strobe && active && !BURST_ADVANCE_N && !SLEEP_REQUEST;
  assign wmask    = lane_mask(GLOBAL_WRITE_N, BYTE_WRITE_ENABLE_N, BYTE_LANE_WRITE_SELECT_N);
  // a processor strobe always opens with a read; writes come on later edges
  assign wr_now   = (|wmask) && ((controller_addr_strobe_ok && selected) || (!strobe && active && !SLEEP_REQUEST));
  assign cur_addr = {hi_q, burst_low(base_q, cnt_q, order_q)};

  always_comb begin
    if (start) begin
      eff_addr = ADDR;
    end else if (burst_advance_n) begin
      eff_addr = {hi_q, burst_low(base_q, burst_t'(cnt_q + `SRAM_CNT_ONE), order_q)};
    end else begin
      eff_addr = cur_addr;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_DESEL;
    end else if (SLEEP_REQUEST) begin
      state_q <= ST_SLEEP;
    end else if (desel) begin
      state_q <= ST_DESEL;
    end else if (start || active) begin
      state_q <= (|wmask && !processor_addr_strobe_ok) ? ST_WRITE : ST_READ;
    end else begin
      state_q <= ST_DESEL;
    end
  end

  // one-clock output mask when an access starts from deselect or sleep
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      first_q <= 1'b0;
    end else begin
      first_q <= start && !active;
    end
  end

  // strap sampled every clock; software keeps it static
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      order_q <= 1'b0;
    end else begin
      order_q <= BURST_ORDER;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      hi_q   <= '0;
      base_q <= `SRAM_CNT_ZERO;
      cnt_q  <= `SRAM_CNT_ZERO;
    end else if (start) begin
      hi_q   <= ADDR[`SRAM_ADDR_W-1:`SRAM_HI_LSB];
      base_q <= ADDR[`SRAM_LOW_W-1:0];
      cnt_q  <= `SRAM_CNT_ZERO;
    end else if (burst_advance_n) begin
      cnt_q  <= burst_t'(cnt_q + `SRAM_CNT_ONE);
    end
  end

  // write data is registered, then committed on the following edge
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      wdata_q   <= '0;
      wr_mask_q <= `SRAM_MASK_NONE;
    end else begin
      wr_pend_q <= wr_now;
      wr_addr_q <= eff_addr;
      wdata_q   <= '{parity: PARITY_LANES_IN, data: DATA_IN};
      wr_mask_q <= wmask;
    end
  end

  // array has no reset so contents survive sleep
  always_ff @(posedge REF_CLK) begin
    if (wr_pend_q) begin
      mem[wr_addr_q] <= merge(mem[wr_addr_q], wdata_q, wr_mask_q);
    end
  end

  // flow-through: no output register, bypass covers a write still pending
  always_comb begin
    rd_word = mem[cur_addr];
    if (wr_pend_q && (wr_addr_q == cur_addr)) begin
      rd_word = merge(mem[cur_addr], wdata_q, wr_mask_q);
    end
  end

  assign DATA_OUT         = rd_word.data;
  assign PARITY_LANES_OUT = rd_word.parity;
  assign LANES_OE_N       = OUTPUT_ENABLE_N || (state_q != ST_READ) || first_q;
  assign SLEEP_ACTIVE     = (state_q == ST_SLEEP);

  sequence s_start;
    start && !wr_now;
  endsequence

  sequence s_step;
    burst_advance_n;
  endsequence

  property p_select;
    @(posedge REF_CLK) disable iff (!RSTN) start |=> active;
  endproperty
  a_select: assert property (p_select) else $error("selected start not active");

  property p_deselect;
    @(posedge REF_CLK) disable iff (!RSTN) desel |=> state_q == ST_DESEL && LANES_OE_N;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect not honoured");

  property p_processor_addr_strobe_ignored;
    @(posedge REF_CLK) disable iff (!RSTN)
      (!PROCESSOR_ADDR_STROBE_N && CHIP_SELECT_A_N && CONTROLLER_ADDR_STROBE_N && !active
       && !SLEEP_REQUEST) |=> !active;
  endproperty
  a_processor_addr_strobe_ignored: assert property (p_processor_addr_strobe_ignored) else $error("strobe taken with select a high");

  property p_drive;
    @(posedge REF_CLK) disable iff (!RSTN)
      (state_q == ST_READ && !first_q && !OUTPUT_ENABLE_N) |-> !LANES_OE_N;
  endproperty
  a_drive: assert property (p_drive) else $error("read lanes not driven");

  property p_first_masked;
    @(posedge REF_CLK) disable iff (!RSTN) (start && !active) |=> LANES_OE_N;
  endproperty
  a_first_masked: assert property (p_first_masked) else $error("first clock drove lanes");

  property p_burst;
    @(posedge REF_CLK) disable iff (!RSTN)
      s_start ##1 s_step |=> cnt_q == `SRAM_CNT_ONE;
  endproperty
  a_burst: assert property (p_burst) else $error("burst count did not step");

  property p_load;
    @(posedge REF_CLK) disable iff (!RSTN) start |=> cur_addr == $past(ADDR);
  endproperty
  a_load: assert property (p_load) else $error("address not loaded");

  property p_processor_addr_strobe_wins;
    @(posedge REF_CLK) disable iff (!RSTN)
      (processor_addr_strobe_ok && selected && !CONTROLLER_ADDR_STROBE_N) |=> state_q == ST_READ && !wr_pend_q;
  endproperty
  a_processor_addr_strobe_wins: assert property (p_processor_addr_strobe_wins) else $error("controller strobe acted");

  property p_sleep;
    @(posedge REF_CLK) disable iff (!RSTN) SLEEP_REQUEST |=> SLEEP_ACTIVE && LANES_OE_N;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

  property p_global;
    @(posedge REF_CLK) disable iff (!RSTN)
      (wr_now && !GLOBAL_WRITE_N) |=> wr_pend_q && wr_mask_q == `SRAM_MASK_ALL;
  endproperty
  a_global: assert property (p_global) else $error("global write missed lanes");

  property p_write_float;
    @(posedge REF_CLK) disable iff (!RSTN) (state_q == ST_WRITE) |-> LANES_OE_N;
  endproperty
  a_write_float: assert property (p_write_float) else $error("lanes driven in write");

  property p_ctrl_load;
    @(posedge REF_CLK) disable iff (!RSTN)
      (controller_addr_strobe_ok && selected) |=> hi_q == $past(ADDR[`SRAM_ADDR_W-1:`SRAM_HI_LSB]);
  endproperty
  a_ctrl_load: assert property (p_ctrl_load) else $error("controller strobe not loaded");

  property p_seed;
    @(posedge REF_CLK) disable iff (!RSTN)
      start |=> cnt_q == `SRAM_CNT_ZERO && base_q == $past(ADDR[`SRAM_LOW_W-1:0]);
  endproperty
  a_seed: assert property (p_seed) else $error("burst counter not seeded");

  // linear order checked against the previous beat, not the xor path
  property p_linear;
    @(posedge REF_CLK) disable iff (!RSTN)
      (burst_advance_n && !order_q) |=> cur_addr[`SRAM_LOW_W-1:0]
        == burst_t'($past(cur_addr[`SRAM_LOW_W-1:0]) + `SRAM_CNT_ONE);
  endproperty
  a_linear: assert property (p_linear) else $error("linear burst order broken");

  property p_wdata;
    @(posedge REF_CLK) disable iff (!RSTN)
      wr_now |=> wr_pend_q && wdata_q == $past({PARITY_LANES_IN, DATA_IN});
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data not captured");

  property p_lane_mask;
    @(posedge REF_CLK) disable iff (!RSTN)
      (wr_now && GLOBAL_WRITE_N) |=> wr_mask_q == ~$past(BYTE_LANE_WRITE_SELECT_N);
  endproperty
  a_lane_mask: assert property (p_lane_mask) else $error("byte lanes wrongly selected");

  property p_oe_float;
    @(posedge REF_CLK) disable iff (!RSTN)
      OUTPUT_ENABLE_N |-> LANES_OE_N;
  endproperty
  a_oe_float: assert property (p_oe_float) else $error("lanes driven with enable high");

  property p_wake;
    @(posedge REF_CLK) disable iff (!RSTN)
      (SLEEP_ACTIVE && !SLEEP_REQUEST) |=> state_q == ST_DESEL;
  endproperty
  a_wake: assert property (p_wake) else $error("sleep exit not to deselect");

endmodule // flow_through_burst_sram_port
`default_nettype wire

// File: tb/bus_master.sv
// bus master model driving the sram port pins one edge at a time
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_defines.svh"
module bus_master
  import sram_port_pkg::*;
(
  input  wire logic                 REF_CLK,
  output addr_t                     ADDR,
  output logic                      CHIP_SELECT_A_N,
  output logic                      CHIP_SELECT_B,
  output logic                      CHIP_SELECT_C_N,
  output logic                      PROCESSOR_ADDR_STROBE_N,
  output logic                      CONTROLLER_ADDR_STROBE_N,
  output logic                      BURST_ADVANCE_N,
  output logic                      GLOBAL_WRITE_N,
  output logic                      BYTE_WRITE_ENABLE_N,
  output lane_mask_t                BYTE_LANE_WRITE_SELECT_N,
  output logic                      OUTPUT_ENABLE_N,
  output logic                      SLEEP_REQUEST,
  output logic                      BURST_ORDER,
  output logic [`SRAM_DATA_W-1:0]   DATA_IN,
  output lane_mask_t                PARITY_LANES_IN,
  input  wire logic [`SRAM_DATA_W-1:0] DATA_OUT,
  input  wire lane_mask_t           PARITY_LANES_OUT,
  input  wire logic                 LANES_OE_N
);
  logic [51:0] q;
  word_s       dq;
  logic        drv;
  // order only changes between bursts; sleep stays low outside its test
  assign {BURST_ORDER, SLEEP_REQUEST, OUTPUT_ENABLE_N, CHIP_SELECT_A_N, CHIP_SELECT_B,
          CHIP_SELECT_C_N, PROCESSOR_ADDR_STROBE_N, CONTROLLER_ADDR_STROBE_N,
          BURST_ADVANCE_N, GLOBAL_WRITE_N, BYTE_WRITE_ENABLE_N, ADDR,
          BYTE_LANE_WRITE_SELECT_N, dq, drv} = q;
  // released lanes show the inverse of our last word, so stale data cannot match
  assign {PARITY_LANES_IN, DATA_IN} = !LANES_OE_N ? {PARITY_LANES_OUT, DATA_OUT}
                                    : drv ? dq : ~dq;
  initial q = {11'h1BF, 20'h0, 2'h3, 18'h0, 1'b0};
  task automatic step(input addr_t a, input logic [10:0] c, input lane_mask_t bw,
                      input word_s d, input logic dr);
    @(posedge REF_CLK);
    q <= {c, a, bw, d, dr};
    #1;
  endtask
endmodule // bus_master
`default_nettype wire

// File: tb/flow_through_burst_sram_port_bench.sv
// self-checking bench for the flow-through burst sram port
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_defines.svh"
module flow_through_burst_sram_port_bench
  import sram_port_pkg::*;
;
  logic       REF_CLK;
  logic       RSTN;
  wire addr_t ADDR;
  wire logic  CHIP_SELECT_A_N, CHIP_SELECT_B, CHIP_SELECT_C_N, BURST_ORDER, SLEEP_REQUEST;
  wire logic  PROCESSOR_ADDR_STROBE_N, CONTROLLER_ADDR_STROBE_N, BURST_ADVANCE_N;
  wire logic  GLOBAL_WRITE_N, BYTE_WRITE_ENABLE_N, OUTPUT_ENABLE_N, LANES_OE_N, SLEEP_ACTIVE;
  wire lane_mask_t BYTE_LANE_WRITE_SELECT_N, PARITY_LANES_IN, PARITY_LANES_OUT;
  wire logic [`SRAM_DATA_W-1:0] DATA_IN, DATA_OUT;
  int         seed = 32'h36F8509D;
  int         failures = 0;
  int         checks = 0;
  int         n;
  logic [2:0] mode;
  logic       ord;
  addr_t      a;
  word_s      mem[addr_t];
  // start, advance and deselect codes: selects, strobes, advance, global, byte enable
  logic [7:0] st[3] = '{8'h57, 8'h55, 8'h56};
  logic [7:0] av[3] = '{8'h5B, 8'h59, 8'h5A};
  logic [7:0] dsl[3] = '{8'hD7, 8'h17, 8'h77};
  flow_through_burst_sram_port flow_through_burst_sram_port_i (
    .REF_CLK, .RSTN, .ADDR, .CHIP_SELECT_A_N, .CHIP_SELECT_B, .CHIP_SELECT_C_N,
    .PROCESSOR_ADDR_STROBE_N, .CONTROLLER_ADDR_STROBE_N, .BURST_ADVANCE_N, .GLOBAL_WRITE_N,
    .BYTE_WRITE_ENABLE_N, .BYTE_LANE_WRITE_SELECT_N, .OUTPUT_ENABLE_N, .SLEEP_REQUEST,
    .BURST_ORDER, .DATA_IN, .PARITY_LANES_IN, .DATA_OUT, .PARITY_LANES_OUT, .LANES_OE_N,
    .SLEEP_ACTIVE);
  bus_master bus_master_i (
    .REF_CLK, .ADDR, .CHIP_SELECT_A_N, .CHIP_SELECT_B, .CHIP_SELECT_C_N,
    .PROCESSOR_ADDR_STROBE_N, .CONTROLLER_ADDR_STROBE_N, .BURST_ADVANCE_N, .GLOBAL_WRITE_N,
    .BYTE_WRITE_ENABLE_N, .BYTE_LANE_WRITE_SELECT_N, .OUTPUT_ENABLE_N, .SLEEP_REQUEST,
    .BURST_ORDER, .DATA_IN, .PARITY_LANES_IN, .DATA_OUT, .PARITY_LANES_OUT, .LANES_OE_N);
  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end
  task automatic cmp_w(input word_s g, input word_s e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_b(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic addr_t nxt(input addr_t b, input int k);
    nxt = b;
    nxt[1:0] = ord ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k);
  endfunction
  function automatic word_s mrg(input word_s o, input word_s w, input lane_mask_t bw);
    mrg = o;
    for (int l = 0; l < 2; l++) begin
      if (!bw[l]) begin
        mrg.data[8*l +: 8] = w.data[8*l +: 8];
        mrg.parity[l] = w.parity[l];
      end
    end
  endfunction
  // w: 0 read, 1 global write, 2 byte write; four beats, deselect, idle
  task automatic burst(input addr_t b, input int w);
    word_s d;
    lane_mask_t bw;
    addr_t x;
    addr_t px;
    mode = {ord, 1'b0, w > 0 ? 1'b1 : 1'($random(seed))};
    for (int k = 0; k < 6; k++) begin
      x = nxt(b, k);
      d = 18'($random(seed));
      bw = 2'($random(seed));
      if (k == 5)
        bus_master_i.step(b, {ord, 2'b00, 8'hDF}, bw, d, 1'b0);
      else if (k == 4)
        bus_master_i.step(b, {mode, dsl[b % 3]}, bw, d, 1'b0);
      else
        bus_master_i.step(b, {mode, k > 0 ? av[w] : st[w]}, bw, d, w > 0);
      if (k == 5 || (k > 0 && w > 0)) cmp_b(LANES_OE_N, 1'b1);
      else if (k > 0) begin
        cmp_w({PARITY_LANES_OUT, DATA_OUT}, mem[px]);
        cmp_b(LANES_OE_N, k == 1 ? 1'b1 : mode[0]);
      end
      if (k < 4 && w == 1) mem[x] = d;
      if (k < 4 && w == 2) mem[x] = mrg(mem[x], d, bw);
      px = x;
    end
  endtask
  // sleep is synchronous, so a few edges are allowed before the flag follows
  task automatic nap(input logic s);
    n = 0;
    do begin
      bus_master_i.step(a, {ord, s, 1'b1, 8'hDF}, 2'h3, 18'h0, 1'b0);
      n++;
    end while (SLEEP_ACTIVE !== s && n < 4);
    cmp_b(SLEEP_ACTIVE, s);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    RSTN = 1'b0;
    repeat (10) @(posedge REF_CLK);
    RSTN <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      a = 20'($random(seed));
      ord = i[0];
      burst(a, 1);
      burst(a, 2);
      burst(a, 0);
      $display("burst test %0d done", i);
    end
    bus_master_i.step(a, {ord, 2'b00, 8'h45}, 2'h0, ~mem[a], 1'b1);
    bus_master_i.step(a ^ 20'h4, {ord, 2'b00, 8'hCF}, 2'h0, mem[a], 1'b0);
    cmp_w({PARITY_LANES_OUT, DATA_OUT}, mem[a]);
    cmp_b(LANES_OE_N, 1'b1);
    bus_master_i.step(a, {ord, 2'b00, 8'hDF}, 2'h3, mem[a], 1'b0);
    cmp_w({PARITY_LANES_OUT, DATA_OUT}, mem[a]);
    cmp_b(LANES_OE_N, 1'b0);
    bus_master_i.step(a, {ord, 2'b01, 8'hDF}, 2'h3, mem[a], 1'b0);
    cmp_b(LANES_OE_N, 1'b1);
    $display("strobe priority test done");
    nap(1'b1);
    nap(1'b0);
    bus_master_i.step(a, {ord, 2'b00, 8'hCF}, 2'h3, 18'h0, 1'b0);
    bus_master_i.step(a, {ord, 2'b00, 8'hDF}, 2'h3, 18'h0, 1'b0);
    cmp_b(LANES_OE_N, 1'b1);
    burst(a, 0);
    $display("sleep test done");
    tally_and_finish();
  end
endmodule // flow_through_burst_sram_port_bench
`default_nettype wire
